// >>> rtl/odt_divider.sv
// binary divider clocked by the oscillator, advancing only while run_i is high
`timescale 1ns/1ps
`default_nettype none
module odt_divider
  import odt_pkg::*;
#(
  parameter int unsigned WIDTH = ODT_DIV_WIDTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             run_i,
  output logic      [WIDTH-1:0] count_o
);

  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count_o;
    if (run_i) begin
      next_count = count_o + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      count_o <= '0;
    end else begin
      count_o <= next_count;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/odt_pkg.sv
// shared constants and types for the oscillator divider tap block
package odt_pkg;

  localparam int unsigned ODT_DIV_WIDTH = 19;
  localparam int unsigned ODT_NUM_TAPS  = 4;
  localparam int unsigned ODT_TAP_BIT0  = 3;
  localparam int unsigned ODT_TAP_BIT1  = 8;
  localparam int unsigned ODT_TAP_BIT2  = 13;
  localparam int unsigned ODT_TAP_BIT3  = 18;
  localparam logic [1:0]  ODT_SEL_RST_A = 2'h0;
  localparam logic [1:0]  ODT_SEL_RST_B = 2'h1;

  typedef enum logic [2:0] {
    ODT_ST_CONFIG = 3'b001,
    ODT_ST_RUN    = 3'b010,
    ODT_ST_OFF    = 3'b100
  } odt_state_t;

  typedef struct packed {
    logic       used;
    logic [1:0] sel_a;
    logic [1:0] sel_b;
  } odt_cfg_t;

  typedef struct packed {
    logic osc_en;
    logic tap_a;
    logic tap_b;
  } odt_out_t;

endpackage

// >>> rtl/odt_top.sv
// oscillator output stage with resynchronised divider taps
`timescale 1ns/1ps
`default_nettype none
module odt_top
  import odt_pkg::*;
#(
  parameter int unsigned DIV_WIDTH = ODT_DIV_WIDTH
) (
  input  wire logic     clk_i,
  input  wire logic     rst_b_i,
  input  wire logic     config_done_i,
  input  wire odt_cfg_t cfg_i,
  output logic          osc_run_o,
  output logic          in_config_o,
  output odt_out_t      user_o
);

  odt_state_t               state;
  odt_state_t               next_state;
  logic                     done_s1;
  logic                     done_s2;
  logic                     used_s1;
  logic                     used_s2;
  logic [1:0]               sel_a_s1;
  logic [1:0]               sel_a_s2;
  logic [1:0]               sel_b_s1;
  logic [1:0]               sel_b_s2;
  logic [DIV_WIDTH-1:0]     count;
  logic [ODT_NUM_TAPS-1:0]  taps;
  logic [ODT_NUM_TAPS-1:0]  tap_sync;
  logic [ODT_NUM_TAPS-1:0]  next_tap_sync;
  logic [1:0]               sel_a;
  logic [1:0]               sel_b;
  logic [1:0]               next_sel_a;
  logic [1:0]               next_sel_b;
  odt_out_t                 next_user;
  logic                     next_osc_run;
  logic                     next_in_config;

  // configuration-state inputs come from outside this clock domain
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      used_s1 <= 1'b0;
      used_s2 <= 1'b0;
      sel_a_s1 <= ODT_SEL_RST_A;
      sel_a_s2 <= ODT_SEL_RST_A;
      sel_b_s1 <= ODT_SEL_RST_B;
      sel_b_s2 <= ODT_SEL_RST_B;
    end else begin
      done_s1 <= config_done_i;
      done_s2 <= done_s1;
      used_s1 <= cfg_i.used;
      used_s2 <= used_s1;
      sel_a_s1 <= cfg_i.sel_a;
      sel_a_s2 <= sel_a_s1;
      sel_b_s1 <= cfg_i.sel_b;
      sel_b_s2 <= sel_b_s1;
    end
  end

  // oscillator keeps running through power-on and configuration
  always_comb begin
    next_state = state;
    unique case (state)
      ODT_ST_CONFIG: begin
        if (done_s2) begin
          next_state = used_s2 ? ODT_ST_RUN : ODT_ST_OFF;
        end
      end
      ODT_ST_RUN: begin
        next_state = ODT_ST_RUN;
      end
      ODT_ST_OFF: begin
        next_state = ODT_ST_OFF;
      end
      default: begin
        next_state = ODT_ST_CONFIG;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= ODT_ST_CONFIG;
    end else begin
      state <= next_state;
    end
  end

  // divider advances whenever the oscillator runs
  odt_divider #(
    .WIDTH (DIV_WIDTH)
  ) u_div (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .run_i   (state != ODT_ST_OFF),
    .count_o (count)
  );

  assign taps = {count[ODT_TAP_BIT3], count[ODT_TAP_BIT2],
                 count[ODT_TAP_BIT1], count[ODT_TAP_BIT0]};

  // selections are static configuration, captured at the end of configuration
  always_comb begin
    next_tap_sync = taps;
    next_sel_a    = sel_a;
    next_sel_b    = sel_b;
    if (state == ODT_ST_CONFIG && done_s2) begin
      next_sel_a = sel_a_s2;
      next_sel_b = sel_b_s2;
    end
    next_osc_run     = (next_state != ODT_ST_OFF);
    next_in_config   = (next_state == ODT_ST_CONFIG);
    next_user.osc_en = (next_state == ODT_ST_RUN);
    next_user.tap_a  = (state == ODT_ST_RUN) & tap_sync[sel_a];
    next_user.tap_b  = (state == ODT_ST_RUN) & tap_sync[sel_b];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tap_sync    <= '0;
      sel_a       <= ODT_SEL_RST_A;
      sel_b       <= ODT_SEL_RST_B;
      osc_run_o   <= 1'b1;
      in_config_o <= 1'b1;
      user_o      <= '0;
    end else begin
      tap_sync    <= next_tap_sync;
      sel_a       <= next_sel_a;
      sel_b       <= next_sel_b;
      osc_run_o   <= next_osc_run;
      in_config_o <= next_in_config;
      user_o      <= next_user;
    end
  end

endmodule
`default_nettype wire

// >>> sim/odt_chk.sv
// assertions on the oscillator divider tap outputs
`timescale 1ns/1ps
`default_nettype none
module odt_chk
  import odt_pkg::*;
(
  input wire logic     clk_i,
  input wire logic     rst_b_i,
  input wire logic     config_done_i,
  input wire odt_cfg_t cfg_i,
  input wire logic     osc_run_o,
  input wire logic     in_config_o,
  input wire odt_out_t user_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_raw_follows: assert property (!in_config_o |-> user_o.osc_en == osc_run_o)
    else $error("osc_en");
  a_run_holds: assert property (!in_config_o |=> !in_config_o)
    else $error("run left");
  // first toggles after configuration may be short, so they are skipped
  a_tap_a_period: assert property ($past(!in_config_o, 4) && cfg_i.sel_a == 2'h0
    && $changed(user_o.tap_a) |=> $stable(user_o.tap_a)[*7] ##1 $changed(user_o.tap_a))
    else $error("tap_a");
  a_tap_b_period: assert property ($past(!in_config_o, 4) && cfg_i.sel_b == 2'h0
    && $changed(user_o.tap_b) |=> $stable(user_o.tap_b)[*7] ##1 $changed(user_o.tap_b))
    else $error("tap_b");
  a_unused_off: assert property (!in_config_o && !osc_run_o |-> user_o == 3'h0)
    else $error("unused");
  a_off_select: assert property ($fell(in_config_o) |-> osc_run_o == cfg_i.used)
    else $error("osc_run");
  a_cfg_clock: assert property (in_config_o |-> osc_run_o)
    else $error("cfg clock");
  a_done_delay: assert property ($rose(config_done_i) |-> ##[2:4] $fell(in_config_o))
    else $error("done delay");
endmodule
`default_nettype wire

// >>> sim/odt_user.sv
// user logic that measures the spacing of edges on one tap
`timescale 1ns/1ps
`default_nettype none
module odt_user (
  input  wire logic clk_i,
  input  wire logic tap_i,
  output var  int   half_o
);
  logic last;
  int   cnt = 0;
  always @(posedge clk_i) begin
    last <= tap_i;
    cnt <= (tap_i !== last) ? 1 : cnt + 1;
    if (tap_i !== last) half_o <= cnt;
  end
endmodule
`default_nettype wire

// >>> sim/test_odt_top.sv
// self-checking bench for the oscillator divider tap block
`timescale 1ns/1ps
`default_nettype none
module test_odt_top import odt_pkg::*; ;
  logic     clk_i = 1'b0;
  logic     rst_b_i = 1'b0;
  logic     config_done_i = 1'b0;
  odt_cfg_t cfg_i = 5'h00;
  logic     osc_run_o;
  logic     in_config_o;
  odt_out_t user_o;
  int       half_a, half_b, n_mismatch = 0, checks_done = 0;
  always #50 clk_i = ~clk_i;
  odt_top uut (.*);
  odt_user ua (.clk_i(clk_i), .tap_i(user_o.tap_a), .half_o(half_a));
  odt_user ub (.clk_i(clk_i), .tap_i(user_o.tap_b), .half_o(half_b));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic boot(input odt_cfg_t c, input int n);
    rst_b_i = 1'b0;
    config_done_i = 1'b0;
    cfg_i = c;
    repeat (8) @(negedge clk_i);
    chk("in_config_o", 32'h1, in_config_o);
    chk("osc_run_o", 32'h1, osc_run_o);
    rst_b_i = 1'b1;
    @(negedge clk_i);
    config_done_i = 1'b1;
    repeat (n) @(negedge clk_i);
    chk("osc_run_o", {31'h0, c.used}, osc_run_o);
    chk("osc_en", {31'h0, c.used}, user_o.osc_en);
  endtask
  task automatic t_fast_taps();
    boot(5'h11, 600);
    chk("half_a", 1 << ODT_TAP_BIT0, half_a);
    chk("half_b", 1 << ODT_TAP_BIT1, half_b);
  endtask
  task automatic t_slow_tap();
    boot(5'h18, 20000);
    chk("half_a", 1 << ODT_TAP_BIT2, half_a);
    chk("half_b", 1 << ODT_TAP_BIT0, half_b);
  endtask
  task automatic t_unused();
    boot(5'h01, 600);
    chk("user_o", 32'h0, {29'h0, user_o});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    t_fast_taps();
    t_slow_tap();
    t_unused();
    tally_and_finish();
  end
  initial begin
    #4000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
bind odt_top odt_chk chk (.*);
`default_nettype wire
